// >>> rtl/ssle_defs.svh
// Constants for the serial sample link encoder
`ifndef SSLE_DEFS_SVH
`define SSLE_DEFS_SVH

// ***********************************
// Frame timing, one line bit per clock
// ***********************************
`define SSLE_FRAME_LAST 5'd19
`define SSLE_GROUP_LAST 5'd9
`define SSLE_SYNC_MIN 2'd2

// ***********************************
// Octet values of control and idle groups
// ***********************************
`define SSLE_K28_5 8'hbc
`define SSLE_K28_7 8'hfc
`define SSLE_D16_2 8'h50
`define SSLE_D5_6 8'hc5
`define SSLE_K28_CODE6 6'h0f
`define SSLE_X_K28 5'd28
`define SSLE_X_D7 5'd7
`define SSLE_Y_D3 3'd3
`define SSLE_Y_ALT 3'd7

// ***********************************
// Encoded comma groups, both polarities
// ***********************************
`define SSLE_CG_K28_5_NEG 10'h0fa
`define SSLE_CG_K28_5_POS 10'h305
`define SSLE_CG_K28_7_NEG 10'h0f8
`define SSLE_CG_K28_7_POS 10'h307

// ***********************************
// Scrambler taps, 1 + x^14 + x^15
// ***********************************
`define SSLE_SCR_TAP_A 13
`define SSLE_SCR_TAP_B 14

// ***********************************
// Register map and fields
// ***********************************
`define SSLE_ADDR_CTRL 4'h0
`define SSLE_ADDR_STATUS 4'h4
`define SSLE_CTRL_RESET 4'h0
`define SSLE_CTRL_FAM 0
`define SSLE_CTRL_IDLE 1
`define SSLE_CTRL_WHITEN 2
`define SSLE_CTRL_FLIP 3

`endif

// >>> rtl/ssle_pkg.sv
// Types shared by the serial sample link encoder
package ssle_pkg;
    typedef enum logic [1:0] {
        SSLE_ST_PREAMBLE = 2'b00,
        SSLE_ST_DATA = 2'b01
    } ssle_state_t;
endpackage

// >>> rtl/ssle_enc_if.sv
// Octet to code-group connection between link logic and coder
`timescale 1ns/1ps
interface ssle_enc_if;
    logic [7:0] octet;
    logic is_k;
    logic rd_in;
    logic [9:0] code;
    logic rd_out;
    modport coder (input octet, input is_k, input rd_in, output code, output rd_out);
    modport user (output octet, output is_k, output rd_in, input code, input rd_out);
endinterface

// >>> rtl/ssle_coder.sv
// Combinational 8B/10B coder with running disparity
`timescale 1ns/1ps
`include "ssle_defs.svh"
module ssle_coder (
    // Octet in, code-group out
    ssle_enc_if.coder enc
);
    // ***********************************
    // Tables, negative-disparity column
    // ***********************************
    function automatic logic [5:0] code6(input logic [4:0] x);
        logic [5:0] c;
        c = 6'h00;
        case (x)
            5'd0: c = 6'h27;
            5'd1: c = 6'h1d;
            5'd2: c = 6'h2d;
            5'd3: c = 6'h31;
            5'd4: c = 6'h35;
            5'd5: c = 6'h29;
            5'd6: c = 6'h19;
            5'd7: c = 6'h38;
            5'd8: c = 6'h39;
            5'd9: c = 6'h25;
            5'd10: c = 6'h15;
            5'd11: c = 6'h34;
            5'd12: c = 6'h0d;
            5'd13: c = 6'h2c;
            5'd14: c = 6'h1c;
            5'd15: c = 6'h17;
            5'd16: c = 6'h1b;
            5'd17: c = 6'h23;
            5'd18: c = 6'h13;
            5'd19: c = 6'h32;
            5'd20: c = 6'h0b;
            5'd21: c = 6'h2a;
            5'd22: c = 6'h1a;
            5'd23: c = 6'h3a;
            5'd24: c = 6'h33;
            5'd25: c = 6'h26;
            5'd26: c = 6'h16;
            5'd27: c = 6'h36;
            5'd28: c = 6'h0e;
            5'd29: c = 6'h2e;
            5'd30: c = 6'h1e;
            default: c = 6'h2b;
        endcase
        return c;
    endfunction

    function automatic logic [3:0] code4(input logic [2:0] y, input logic alt);
        logic [3:0] c;
        c = 4'h0;
        case (y)
            3'd0: c = 4'hb;
            3'd1: c = 4'h9;
            3'd2: c = 4'h5;
            3'd3: c = 4'hc;
            3'd4: c = 4'hd;
            3'd5: c = 4'ha;
            3'd6: c = 4'h6;
            default: c = alt ? 4'h7 : 4'he;
        endcase
        return c;
    endfunction

    // Disparity after one sub-block: more ones positive, more zeros negative
    function automatic logic rd_after(input logic rd, input logic [5:0] bits, input int half);
        int ones;
        ones = $countones(bits);
        if (ones > half)
            return 1'b1;
        else if (ones < half)
            return 1'b0;
        return rd;
    endfunction

    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] c6;
    logic [3:0] c4;
    logic rd6;
    logic alt;

    // ***********************************
    // Sub-block selection
    // ***********************************
    always_comb
    begin
        x = enc.octet[4:0];
        y = enc.octet[7:5];
        c6 = (enc.is_k && x == `SSLE_X_K28) ? `SSLE_K28_CODE6 : code6(x);
        // Positive disparity takes the complement of unbalanced groups
        if (enc.rd_in && ($countones(c6) != 3 || x == `SSLE_X_D7))
            c6 = ~c6;
        rd6 = rd_after(enc.rd_in, c6, 3);
        alt = enc.is_k || (!rd6 && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
              (rd6 && (x == 5'd11 || x == 5'd13 || x == 5'd14));
        c4 = code4(y, alt);
        if (rd6 && ($countones(c4) != 2 || y == `SSLE_Y_D3))
            c4 = ~c4;
        // Control groups key balanced trailers to the entry disparity, not the six-bit result
        else if (enc.is_k && enc.rd_in && $countones(c4) == 2 && y != `SSLE_Y_D3)
            c4 = ~c4;
        enc.code = {c6, c4};
        enc.rd_out = rd_after(rd6, {2'b00, c4}, 2);
    end
endmodule

// >>> rtl/ssle_link_tx.sv
// Serial sample link transmitter: framing, sync, scrambling, alignment marks
// Notes on behaviour
// - Each sample goes out as two code-groups.
// - Every octet passes the 8B/10B coder.
// - Data groups cover all 256 octet values.
// - Coder also makes the twelve K groups.
// - Optional self-synchronising scrambler, 1+x14+x15.
// - Alignment mark swaps a last group of D28.7 for K28.7.
// - Marks only after initial synchronisation.
// - Idle mode preamble: K28.5 then D16.2/D5.6.
// - Normal sync preamble is repeated K28.5.
// - Preamble runs to frame end, data on boundary.
// - Disparity judged over six then four bits.
// - Ones-heavy positive, zeros-heavy negative, equal keeps.
// - Group polarity picked by running disparity.
// - Scrambling happens before the coder.
// - Mark enable high turns substitution on.
// - Top-bit flip inverts the sample MSB.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ssle_defs.svh"
module ssle_link_tx (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // Sample stream
    input wire logic [15:0] SAMPLE_IN,
    output logic SAMPLE_TAKE,
    // Link
    input wire logic SYNC_N,
    output logic SERIAL_LINE_OUT,
    // Register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA
);
    // ***********************************
    // Helpers
    // ***********************************
    // Serial self-synchronising scrambler, MSB first; returns {state, data}
    function automatic logic [30:0] whiten(input logic [14:0] st, input logic [15:0] d);
        logic [14:0] s;
        logic [15:0] o;
        logic b;
        s = st;
        o = 16'h0000;
        for (int i = 15; i >= 0; i--)
        begin
            b = d[i] ^ s[`SSLE_SCR_TAP_A] ^ s[`SSLE_SCR_TAP_B];
            o[i] = b;
            s = {s[13:0], b};
        end
        return {s, o};
    endfunction

    // ***********************************
    // State
    // ***********************************
    ssle_pkg::ssle_state_t state_reg, state_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [9:0] shift_reg, shift_next;
    logic rd_reg, rd_next;
    logic synced_reg, synced_next;
    logic [7:0] low_hold_reg, low_hold_next;
    logic [14:0] scr_reg, scr_next;
    logic [1:0] low_cnt_reg, low_cnt_next;
    logic [3:0] ctrl_reg, ctrl_next;
    logic [7:0] rdata_reg, rdata_next;
    logic sync_meta_reg, sync_sync_reg;
    logic load0, load1, sync_req, fam_sub;
    logic [15:0] flipped;
    logic [30:0] scr_out;
    logic [15:0] proc_word;
    ssle_enc_if enc_bus ();

    ssle_coder u_coder (
        .enc(enc_bus)
    );

    assign load0 = (cnt_reg == `SSLE_FRAME_LAST);
    assign load1 = (cnt_reg == `SSLE_GROUP_LAST);
    assign sync_req = (low_cnt_reg >= `SSLE_SYNC_MIN);
    assign SAMPLE_TAKE = load0;
    assign SERIAL_LINE_OUT = shift_reg[9];
    assign REG_RDATA = rdata_reg;

    // ***********************************
    // Next-state logic
    // ***********************************
    always_comb
    begin
        state_next = state_reg;
        cnt_next = load0 ? 5'd0 : cnt_reg + 5'd1;
        shift_next = {shift_reg[8:0], 1'b0};
        rd_next = rd_reg;
        synced_next = synced_reg;
        low_hold_next = low_hold_reg;
        scr_next = scr_reg;
        low_cnt_next = low_cnt_reg;
        ctrl_next = ctrl_reg;
        fam_sub = 1'b0;
        flipped = SAMPLE_IN ^ {ctrl_reg[`SSLE_CTRL_FLIP], 15'h0000};
        scr_out = whiten(scr_reg, flipped);
        proc_word = ctrl_reg[`SSLE_CTRL_WHITEN] ? scr_out[15:0] : flipped;
        enc_bus.octet = `SSLE_K28_5;
        enc_bus.is_k = 1'b1;
        enc_bus.rd_in = rd_reg;
        if (load0)
        begin
            // Request level sampled once per sample period
            if (sync_sync_reg)
                low_cnt_next = 2'd0;
            else if (!sync_req)
                low_cnt_next = low_cnt_reg + 2'd1;
            // Mode change only here, so a withdrawn request finishes its frame
            case (state_reg)
                ssle_pkg::SSLE_ST_PREAMBLE:
                    if (!sync_req)
                    begin
                        state_next = ssle_pkg::SSLE_ST_DATA;
                        synced_next = 1'b1;
                    end
                ssle_pkg::SSLE_ST_DATA:
                    if (sync_req)
                        state_next = ssle_pkg::SSLE_ST_PREAMBLE;
                default:
                    state_next = ssle_pkg::SSLE_ST_PREAMBLE;
            endcase
            if (state_next == ssle_pkg::SSLE_ST_DATA)
            begin
                enc_bus.octet = proc_word[15:8];
                enc_bus.is_k = 1'b0;
                low_hold_next = proc_word[7:0];
                if (ctrl_reg[`SSLE_CTRL_WHITEN])
                    scr_next = scr_out[30:16];
            end
            shift_next = enc_bus.code;
            rd_next = enc_bus.rd_out;
        end
        else if (load1)
        begin
            if (state_reg == ssle_pkg::SSLE_ST_PREAMBLE)
            begin
                if (ctrl_reg[`SSLE_CTRL_IDLE])
                begin
                    enc_bus.octet = rd_reg ? `SSLE_D16_2 : `SSLE_D5_6;
                    enc_bus.is_k = 1'b0;
                end
            end
            else
            begin
                // Receiver puts the marked octet back, so only that value is swapped
                fam_sub = ctrl_reg[`SSLE_CTRL_FAM] && synced_reg && low_hold_reg == `SSLE_K28_7;
                enc_bus.octet = low_hold_reg;
                enc_bus.is_k = fam_sub;
            end
            shift_next = enc_bus.code;
            rd_next = enc_bus.rd_out;
        end
        if (REG_WR && REG_ADDR == `SSLE_ADDR_CTRL)
            ctrl_next = REG_WDATA[3:0];
        if (REG_RD && REG_ADDR == `SSLE_ADDR_CTRL)
            rdata_next = {4'h0, ctrl_reg};
        else if (REG_RD && REG_ADDR == `SSLE_ADDR_STATUS)
            rdata_next = {4'h0, rd_reg, synced_reg, state_reg == ssle_pkg::SSLE_ST_PREAMBLE, sync_req};
        else
            rdata_next = 8'h00;
    end

    // ***********************************
    // Registers
    // ***********************************
    always_ff @(posedge MCLK)
    begin
        sync_meta_reg <= SYNC_N;
        sync_sync_reg <= sync_meta_reg;
        if (!RSTN)
        begin
            state_reg <= ssle_pkg::SSLE_ST_PREAMBLE;
            cnt_reg <= `SSLE_FRAME_LAST;
            shift_reg <= 10'h000;
            rd_reg <= 1'b0;
            synced_reg <= 1'b0;
            low_hold_reg <= 8'h00;
            scr_reg <= 15'h0000;
            low_cnt_reg <= 2'd0;
            ctrl_reg <= `SSLE_CTRL_RESET;
            rdata_reg <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            rd_reg <= rd_next;
            synced_reg <= synced_next;
            low_hold_reg <= low_hold_next;
            scr_reg <= scr_next;
            low_cnt_reg <= low_cnt_next;
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    // ***********************************
    // Assertions
    // ***********************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    property p_frame_len;
        SAMPLE_TAKE |=> (!SAMPLE_TAKE) [*8] ##1 (!SAMPLE_TAKE) [*8] ##1 (!SAMPLE_TAKE) [*3]
            ##1 SAMPLE_TAKE;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not twenty bits");

    property p_rd_start;
        disable iff (1'b0) !RSTN |=> !rd_reg;
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("disparity not negative after reset");

    property p_comma_preamble;
        (load0 || load1) && state_next == ssle_pkg::SSLE_ST_PREAMBLE && state_reg == state_next &&
            !ctrl_reg[`SSLE_CTRL_IDLE] |=> shift_reg == `SSLE_CG_K28_5_NEG || shift_reg == `SSLE_CG_K28_5_POS;
    endproperty
    a_comma_preamble: assert property (p_comma_preamble) else $error("preamble group not K28.5");

    property p_idle_set;
        load1 && state_reg == ssle_pkg::SSLE_ST_PREAMBLE && ctrl_reg[`SSLE_CTRL_IDLE] |=> !rd_reg;
    endproperty
    a_idle_set: assert property (p_idle_set) else $error("idle set ends positive");

    property p_mark_after_sync;
        fam_sub |-> synced_reg && state_reg == ssle_pkg::SSLE_ST_DATA;
    endproperty
    a_mark_after_sync: assert property (p_mark_after_sync) else $error("mark during preamble");

    property p_mark_sent;
        load1 && state_reg == ssle_pkg::SSLE_ST_DATA && ctrl_reg[`SSLE_CTRL_FAM] && low_hold_reg == `SSLE_K28_7
            |=> shift_reg == `SSLE_CG_K28_7_NEG || shift_reg == `SSLE_CG_K28_7_POS;
    endproperty
    a_mark_sent: assert property (p_mark_sent) else $error("K28.7 mark missing");

    property p_rd_track;
        load0 || load1 |=> ($countones(shift_reg) == 6 && rd_reg) || ($countones(shift_reg) == 4 && !rd_reg) ||
            ($countones(shift_reg) == 5 && rd_reg == $past(rd_reg));
    endproperty
    a_rd_track: assert property (p_rd_track) else $error("running disparity wrong");

    property p_balance;
        load0 || load1 |=> !($countones(shift_reg) == 6 && $past(rd_reg)) && !($countones(shift_reg) == 4 && !$past(rd_reg));
    endproperty
    a_balance: assert property (p_balance) else $error("group polarity wrong");

    property p_boundary;
        state_reg != $past(state_reg) |-> $past(load0);
    endproperty
    a_boundary: assert property (p_boundary) else $error("mode change off frame boundary");

    property p_flip;
        load0 && state_next == ssle_pkg::SSLE_ST_DATA && !ctrl_reg[`SSLE_CTRL_WHITEN]
            |-> enc_bus.octet[7] == (SAMPLE_IN[15] ^ ctrl_reg[`SSLE_CTRL_FLIP]);
    endproperty
    a_flip: assert property (p_flip) else $error("top bit flip wrong");

    property p_sync_enter;
        load0 && state_reg == ssle_pkg::SSLE_ST_DATA && sync_req |=> state_reg == ssle_pkg::SSLE_ST_PREAMBLE;
    endproperty
    a_sync_enter: assert property (p_sync_enter) else $error("sync request not answered");

    property p_line_shift;
        !(load0 || load1) |=> SERIAL_LINE_OUT == $past(shift_reg[8]);
    endproperty
    a_line_shift: assert property (p_line_shift) else $error("line bit order wrong");

    property p_rdata_idle;
        !REG_RD |=> REG_RDATA == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

    c_comma_pos: cover property (load0 && state_reg == ssle_pkg::SSLE_ST_PREAMBLE && rd_reg);

    c_idle_pre: cover property (load1 && state_reg == ssle_pkg::SSLE_ST_PREAMBLE && ctrl_reg[`SSLE_CTRL_IDLE]);
    c_mark: cover property (fam_sub);
    c_sync_done: cover property (state_reg == ssle_pkg::SSLE_ST_PREAMBLE ##1 state_reg == ssle_pkg::SSLE_ST_DATA);
    c_whiten: cover property (load0 && ctrl_reg[`SSLE_CTRL_WHITEN] && state_next == ssle_pkg::SSLE_ST_DATA);
endmodule

// >>> testbench/ssle_rx_model.sv
// Receiver model: deserialises, decodes, descrambles and requests sync
`timescale 1ns/1ps
module ssle_rx_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Line side
    input wire logic line_in,
    input wire logic take,
    output logic sync_n,
    // Bench side
    input wire logic whiten,
    input wire logic go,
    output logic stb,
    output logic [17:0] grp,
    output logic rd_mid,
    output logic rd_now,
    output logic [15:0] smp,
    output logic [7:0] bad
);
    // ****
    // Code tables, negative forms
    // ****
    localparam logic [5:0] T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
        6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
    logic [18:0] fr;
    logic [4:0] pos;
    logic [14:0] st;
    logic [1:0] lows;

    initial
    begin
        sync_n = 1'h1;
        stb = 1'h0;
        bad = 8'h0;
    end

    function automatic logic [9:0] enc(input logic [7:0] v, input logic k, input logic rd);
        logic [5:0] a;
        logic [3:0] b;
        logic r;
        if (k && rd)
            return ~enc(v, 1'h1, 1'h0);
        a = k ? 6'h0f : T6[v[4:0]];
        r = ($countones(a) == 3) ? rd : !rd;
        if (rd && ($countones(a) != 3 || v[4:0] == 5'h07))
            a = ~a;
        b = T4[v[7:5]];
        if (v[7:5] == 3'h7 && (k || (!r && (v[4:0] == 5'h11 || v[4:0] == 5'h12 || v[4:0] == 5'h14))
            || (r && (v[4:0] == 5'h0b || v[4:0] == 5'h0d || v[4:0] == 5'h0e))))
            b = 4'h7;
        if (r && (v[7:5] == 3'h0 || v[7:5] == 3'h3 || v[7:5] == 3'h4 || v[7:5] == 3'h7))
            b = ~b;
        return {a, b};
    endfunction

    function automatic logic rd_after(input logic [9:0] cg, input logic rd);
        logic r;
        r = ($countones(cg[9:4]) > 3) ? 1'h1 : ($countones(cg[9:4]) < 3) ? 1'h0 : rd;
        return ($countones(cg[3:0]) > 2) ? 1'h1 : ($countones(cg[3:0]) < 2) ? 1'h0 : r;
    endfunction

    // Returns valid, control flag, octet
    function automatic logic [9:0] dec(input logic [9:0] cg, input logic rd);
        for (int i = 0; i < 256; i++)
            if (enc(8'(i), 1'h0, rd) == cg)
                return {2'h2, 8'(i)};
        if (enc(8'hbc, 1'h1, rd) == cg)
            return {2'h3, 8'hbc};
        if (enc(8'hfc, 1'h1, rd) == cg)
            return {2'h3, 8'hfc};
        return 10'h0;
    endfunction

    // ****
    // Frame capture, aligned to the sample take
    // ****
    always @(posedge mclk)
    begin
        logic [19:0] f;
        logic [9:0] g1;
        logic [9:0] g2;
        logic [15:0] s;
        logic [14:0] t;
        logic r1;
        f = {fr, line_in};
        fr <= f[18:0];
        pos <= take ? 5'h0 : pos + 5'h1;
        stb <= 1'h0;
        if (!rstn)
        begin
            rd_now <= 1'h0;
            sync_n <= 1'h1;
        end
        else if (pos == 5'h13)
        begin
            r1 = rd_after(f[19:10], rd_now);
            g1 = dec(f[19:10], rd_now);
            g2 = dec(f[9:0], r1);
            if (!(g1[9] && g2[9]))
                bad <= bad + 8'h1;
            rd_mid <= r1;
            rd_now <= rd_after(f[9:0], r1);
            grp <= {g1[8:0], g2[8:0]};
            stb <= 1'h1;
            if (!g1[8])
            begin
                s = {g1[7:0], g2[7:0]};
                t = st;
                // Self-aligning: state is the received bits, so no alignment signal
                for (int i = 15; i >= 0; i--)
                begin
                    smp[i] <= whiten ? s[i] ^ t[13] ^ t[14] : s[i];
                    t = {t[13:0], s[i]};
                end
                st <= t;
            end
            if (!sync_n)
                lows <= lows + {1'h0, lows != 2'h3};
            if (!sync_n && g1[8] && lows >= 2'h2)
                sync_n <= 1'h1;
        end
        if (go)
        begin
            sync_n <= 1'h0;
            lows <= 2'h0;
        end
    end
endmodule

// >>> testbench/test_serial_sample_link_encoder.sv
// Self-checking bench for the serial sample link transmitter
`timescale 1ns/1ps
module test_serial_sample_link_encoder;
    typedef struct packed {
        logic [3:0] ctrl;
        logic [15:0] smp;
        logic [17:0] exp;
    } ssle_row_t;
    localparam ssle_row_t ROWS [6] = '{
        '{4'h0, 16'h1234, {1'h0, 8'h12, 1'h0, 8'h34}},
        '{4'h8, 16'h1234, {1'h0, 8'h92, 1'h0, 8'h34}},
        '{4'h8, 16'h8001, {1'h0, 8'h00, 1'h0, 8'h01}},
        '{4'h0, 16'h00fc, {1'h0, 8'h00, 1'h0, 8'hfc}},
        '{4'h1, 16'h00fc, {1'h0, 8'h00, 1'h1, 8'hfc}},
        '{4'h9, 16'hfcfc, {1'h0, 8'h7c, 1'h1, 8'hfc}}};
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic [15:0] sample_in = 16'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic whiten = 1'h0;
    logic go = 1'h0;
    logic sample_take, sync_n, line, stb, rd_mid, rd_now;
    logic [7:0] reg_rdata, bad, rdat;
    logic [15:0] rx_smp;
    logic [17:0] grp;
    int error_cnt = 0;
    int tests_run = 0;

    always #20 mclk = ~mclk;

    ssle_link_tx ssle_link_tx_inst (.MCLK(mclk), .RSTN(rstn), .SAMPLE_IN(sample_in), .SAMPLE_TAKE(sample_take),
        .SYNC_N(sync_n), .SERIAL_LINE_OUT(line), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
    ssle_rx_model ssle_rx_model_inst (.mclk(mclk), .rstn(rstn), .line_in(line), .take(sample_take),
        .sync_n(sync_n), .whiten(whiten), .go(go), .stb(stb), .grp(grp), .rd_mid(rd_mid),
        .rd_now(rd_now), .smp(rx_smp), .bad(bad));

    // ****
    // Shared tasks
    // ****
    task automatic results();
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(input logic [17:0] got, input logic [17:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic do_reset();
        rstn <= 1'h0;
        repeat (8) @(posedge mclk);
        cmp({17'h0, line}, 18'h0, "line in reset");
        cmp({17'h0, sample_take}, 18'h1, "take in reset");
        rstn <= 1'h1;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        @(posedge mclk);
        cmp({10'h0, reg_rdata}, {10'h0, exp}, "register read");
    endtask

    // Bounded waits; running out ends the run
    task automatic wait_on(input logic which);
        for (int i = 0; i < 25; i++)
        begin
            @(posedge mclk);
            if ((which ? stb : sample_take) === 1'h1)
                return;
        end
        cmp(18'h0, 18'h1, "wait ran out");
        results();
    endtask

    // Sample is held from one take edge and consumed at the next
    task automatic xfer(input logic [15:0] s);
        wait_on(1'h0);
        sample_in <= s;
        wait_on(1'h0);
        wait_on(1'h0);
        wait_on(1'h1);
    endtask

    task automatic sync_run(input logic idle);
        int n;
        n = 0;
        go <= 1'h1;
        @(posedge mclk);
        go <= 1'h0;
        for (int i = 0; i < 12; i++)
        begin
            wait_on(1'h1);
            if (grp[17] === 1'h1)
            begin
                n++;
                if (idle)
                begin
                    cmp(grp, {1'h1, 8'hbc, 1'h0, rd_mid ? 8'h50 : 8'hc5}, "idle set");
                    cmp({17'h0, rd_now}, 18'h0, "idle end disparity");
                end
                else
                    cmp(grp, {1'h1, 8'hbc, 1'h1, 8'hbc}, "comma preamble");
            end
            else if (n > 0)
            begin
                cmp(grp, {1'h0, 8'h00, 1'h1, 8'hfc}, "first data frame");
                return;
            end
        end
        cmp(18'h0, 18'h1, "no preamble");
    endtask

    // ****
    // Main sequence
    // ****
    initial
    begin
        do_reset();
        reg_read(4'h4, 8'h04);
        reg_read(4'h0, 8'h00);
        reg_write(4'h0, 8'hff);
        reg_write(4'h8, 8'h00);
        reg_read(4'h0, 8'h0f);
        reg_read(4'h8, 8'h00);
        @(posedge mclk);
        cmp({10'h0, reg_rdata}, 18'h0, "read data after its cycle");
        foreach (ROWS[i])
        begin
            reg_write(4'h0, {4'h0, ROWS[i].ctrl});
            xfer(ROWS[i].smp);
            cmp(grp, ROWS[i].exp, "row frame");
        end
        reg_write(4'h0, 8'h00);
        for (int v = 0; v < 256; v++)
        begin
            xfer({v[7:0], ~v[7:0]});
            cmp(grp, {1'h0, v[7:0], 1'h0, ~v[7:0]}, "octet sweep");
        end
        reg_write(4'h0, 8'h0c);
        whiten <= 1'h1;
        for (int i = 0; i < 6; i++)
        begin
            xfer(16'h1357 + 16'(i) * 16'h2222);
            // First recovered sample is lost while the descrambler aligns
            if (i > 0)
                cmp({2'h0, rx_smp}, {2'h0, (16'h1357 + 16'(i) * 16'h2222) ^ 16'h8000}, "whitened");
        end
        reg_write(4'h0, 8'h01);
        whiten <= 1'h0;
        xfer(16'h00fc);
        sync_run(1'h0);
        reg_write(4'h0, 8'h03);
        xfer(16'h00fc);
        sync_run(1'h1);
        do_reset();
        reg_read(4'h0, 8'h00);
        xfer(16'h0f0f);
        cmp(grp, {1'h0, 8'h0f, 1'h0, 8'h0f}, "after second reset");
        cmp({10'h0, bad}, 18'h0, "invalid code-groups");
        results();
    end
endmodule
